// ===== rtl/gdp_io_port.sv
// Function
// - set or clear single pins independently
// - three locations: output, direction, input
// - input read only, others read write
// - global disable kills all pull-ups
// - three bits per pin, same position
// - direction one output, zero input
// - input with data one gets pull-up
// - reset tri-states pins without clock
// - output pin drives its data bit
// - pull-up only for 0,1,0, other input codes Hi-Z
// - pin level readable via input bit outside reset (reset holds it at 0)
// - falling-edge latch then rising-edge register
// - written value readable after one clock
// - alternate pins leave others untouched
// - pull-up exactly when code equals 0b010 and the pin is not alternate
`timescale 1ns/10ps
`default_nettype none
module gdp_io_port #(
  parameter int W = gdp_pkg::PORT_WIDTH
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire gdp_pkg::gdp_op_t dirOp,
  input  wire logic [W-1:0]     dirWrData,
  input  wire logic [2:0]       dirBitSel,
  input  wire gdp_pkg::gdp_op_t outOp,
  input  wire logic [W-1:0]     outWrData,
  input  wire logic [2:0]       outBitSel,
  input  wire logic             globalPullupDisable,
  input  wire logic [W-1:0]     altEnable,
  input  wire logic [W-1:0]     altDriveEn,
  input  wire logic [W-1:0]     altDriveVal,
  input  wire logic [W-1:0]     padIn,
  output var  logic [W-1:0]     padOut,
  output var  logic [W-1:0]     padOe,
  output var  logic [W-1:0]     pullupEn,
  output var  logic [W-1:0]     portDirectionRegister,
  output var  logic [W-1:0]     portOutputRegister,
  output var  logic [W-1:0]     portInputRegister
);
  import gdp_pkg::*;

  logic [W-1:0] dir_r;
  logic [W-1:0] out_r;

  function automatic logic [W-1:0] applyOp(input gdp_op_t op,
                                           input logic [W-1:0] cur,
                                           input logic [W-1:0] wd,
                                           input logic [2:0] sel);
    logic [W-1:0] mask;
    mask = '0;
    mask[sel] = 1'b1;
    case (op)
      GDP_OP_WRITE: applyOp = wd;
      GDP_OP_SET:   applyOp = cur | mask;
      GDP_OP_CLEAR: applyOp = cur & ~mask;
      default:      applyOp = cur;
    endcase
  endfunction : applyOp

  // =====================================================
  // direction register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dir_r <= DIR_RESET;
    end else begin
      dir_r <= applyOp(dirOp, dir_r, dirWrData, dirBitSel);
    end
  end

  // =====================================================
  // output / pull-up register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      out_r <= OUT_RESET;
    end else begin
      out_r <= applyOp(outOp, out_r, outWrData, outBitSel);
    end
  end

  // read-back of stored values, not pin levels
  assign portDirectionRegister = dir_r;
  assign portOutputRegister    = out_r;

  // =====================================================
  // per-pin logic at matching bit positions
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_pin
      gdp_pin_drive u_drive (
        .rst_n         (rst_n),
        .dirBit        (dir_r[i]),
        .outBit        (out_r[i]),
        .pullupDisable (globalPullupDisable),
        .altEnable     (altEnable[i]),
        .altDriveEn    (altDriveEn[i]),
        .altDriveVal   (altDriveVal[i]),
        .padOut        (padOut[i]),
        .padOe         (padOe[i]),
        .pullupEn      (pullupEn[i])
      );
      gdp_pin_sync u_sync (
        .clock     (clock),
        .rst_n     (rst_n),
        .padIn     (padIn[i]),
        .sampleOut (portInputRegister[i])
      );
    end
  endgenerate

  // =====================================================
  // checks
  AST_PULLUP_DECODE: assert property (
    @(posedge clock) disable iff (!rst_n)
    (altEnable == '0) |->
      (pullupEn == (~dir_r & out_r & {W{~globalPullupDisable}})))
    else $error("pull-up decode wrong");

  AST_GLOBAL_DISABLE: assert property (
    @(posedge clock) disable iff (!rst_n)
    globalPullupDisable |-> (pullupEn == '0))
    else $error("pull-up active while globally disabled");

  AST_DRIVE_DIR: assert property (
    @(posedge clock) disable iff (!rst_n)
    (altEnable == '0) |-> (padOe == dir_r))
    else $error("output enable differs from direction");

  AST_DRIVE_VAL: assert property (
    @(posedge clock) disable iff (!rst_n)
    (altEnable == '0) |-> ((padOut & dir_r) == (out_r & dir_r)))
    else $error("driven value differs from data");

  AST_PULLUP_OFF_OUT: assert property (
    @(posedge clock) disable iff (!rst_n)
    (pullupEn & dir_r) == '0)
    else $error("pull-up on an output pin");

  AST_SET_ONE_BIT: assert property (
    @(posedge clock) disable iff (!rst_n)
    (dirOp == GDP_OP_SET) |=>
      (dir_r == ($past(dir_r) | (W'(1) << $past(dirBitSel)))))
    else $error("bit set disturbed other pins");

  AST_CLR_ONE_BIT: assert property (
    @(posedge clock) disable iff (!rst_n)
    (outOp == GDP_OP_CLEAR) |=>
      (out_r == ($past(out_r) & ~(W'(1) << $past(outBitSel)))))
    else $error("bit clear disturbed other pins");

  // a level held over three samples must have reached the input bit
  AST_SYNC_LATENCY: assert property (
    @(posedge clock) disable iff (!rst_n)
    ($past(rst_n, 2) && (padIn == $past(padIn)) &&
     ($past(padIn) == $past(padIn, 2))) |-> (portInputRegister == padIn))
    else $error("input bit lags a settled pin level");

  AST_HOLD: assert property (
    @(posedge clock) disable iff (!rst_n)
    (dirOp == GDP_OP_NONE) |=> $stable(dir_r))
    else $error("direction changed without access");

  AST_RESET_TRI: assert property (
    @(posedge clock) $rose(rst_n) |-> (padOe == '0 || altEnable != '0)
      or (dir_r == DIR_RESET))
    else $error("pins not tri-stated after reset");

  // =====================================================
  // register access checks
  AST_CLR_DIR_BIT: assert property (
    @(posedge clock) disable iff (!rst_n)
    (dirOp == GDP_OP_CLEAR) |=>
      (dir_r == ($past(dir_r) & ~(W'(1) << $past(dirBitSel)))))
    else $error("direction clear disturbed other pins");

  AST_SET_OUT_BIT: assert property (
    @(posedge clock) disable iff (!rst_n)
    (outOp == GDP_OP_SET) |=>
      (out_r == ($past(out_r) | (W'(1) << $past(outBitSel)))))
    else $error("data set disturbed other pins");

  AST_WRITE_DIR: assert property (
    @(posedge clock) disable iff (!rst_n)
    (dirOp == GDP_OP_WRITE) |=> (dir_r == $past(dirWrData)))
    else $error("direction write lost");

  AST_WRITE_OUT: assert property (
    @(posedge clock) disable iff (!rst_n)
    (outOp == GDP_OP_WRITE) |=> (out_r == $past(outWrData)))
    else $error("data write lost");

  AST_HOLD_OUT: assert property (
    @(posedge clock) disable iff (!rst_n)
    (outOp == GDP_OP_NONE) |=> $stable(out_r))
    else $error("data changed without access");

  AST_RESET_CLEAR: assert property (
    @(posedge clock) $rose(rst_n) |-> ((dir_r == '0) && (out_r == '0)))
    else $error("registers not cleared by reset");

  // =====================================================
  // pull-up and override checks
  AST_PULLUP_NEEDS_DATA: assert property (
    @(posedge clock) disable iff (!rst_n)
    (pullupEn & ~out_r) == '0)
    else $error("pull-up on a pin whose data bit is zero");

  AST_ALT_OE: assert property (
    @(posedge clock) disable iff (!rst_n)
    ((padOe ^ altDriveEn) & altEnable) == '0)
    else $error("overridden pin ignores its drive enable");

  AST_ALT_OTHERS: assert property (
    @(posedge clock) disable iff (!rst_n)
    ((padOe ^ dir_r) & ~altEnable) == '0)
    else $error("override leaked into plain pins");

  AST_ALT_PULL_OFF: assert property (
    @(posedge clock) disable iff (!rst_n)
    (pullupEn & altEnable) == '0)
    else $error("pull-up on an overridden pin");
endmodule : gdp_io_port
`default_nettype wire

// ===== rtl/gdp_pkg.sv
package gdp_pkg;
  // =====================================================
  // port geometry and reset values
  localparam int          PORT_WIDTH     = 8;
  localparam logic [7:0]  DIR_RESET      = 8'h00;
  localparam logic [7:0]  OUT_RESET      = 8'h00;
  // =====================================================
  // pull-up decode code {dir, out, disable}
  localparam logic [2:0]  PULLUP_CODE    = 3'h2;
  // =====================================================
  // bit operation encodings
  typedef enum logic [1:0] {
    GDP_OP_NONE,
    GDP_OP_WRITE,
    GDP_OP_SET,
    GDP_OP_CLEAR
  } gdp_op_t;
  // =====================================================
  // timing: software write to input bit, clock periods
  localparam int          READBACK_CYCLES = 1;
endpackage : gdp_pkg

// ===== rtl/gdp_pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
// =====================================================
// per-pin input synchronizer
module gdp_pin_sync (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic padIn,
  output var  logic sampleOut
);
  import gdp_pkg::*;

  logic latchLow_r;

  // =====================================================
  // held on falling edge, loaded on next rising edge
  always_ff @(negedge clock or negedge rst_n) begin
    if (!rst_n) begin
      latchLow_r <= 1'b0;
    end else begin
      latchLow_r <= padIn;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sampleOut <= 1'b0;
    end else begin
      sampleOut <= latchLow_r;
    end
  end
endmodule : gdp_pin_sync
`default_nettype wire

// ===== rtl/gdp_pin_drive.sv
`timescale 1ns/10ps
`default_nettype none
// =====================================================
// per-pin driver and pull-up decode
module gdp_pin_drive (
  input  wire logic rst_n,
  input  wire logic dirBit,
  input  wire logic outBit,
  input  wire logic pullupDisable,
  input  wire logic altEnable,
  input  wire logic altDriveEn,
  input  wire logic altDriveVal,
  output var  logic padOut,
  output var  logic padOe,
  output var  logic pullupEn
);
  import gdp_pkg::*;

  function automatic logic pullDecode(input logic d, input logic o,
                                      input logic p);
    pullDecode = ({d, o, p} == PULLUP_CODE);
  endfunction : pullDecode

  // =====================================================
  // decode: reset tri-states without needing a clock
  always_comb begin
    padOe    = 1'b0;
    padOut   = 1'b0;
    pullupEn = 1'b0;
    if (rst_n) begin
      if (altEnable) begin
        padOe  = altDriveEn;
        padOut = altDriveVal;
      end else begin
        padOe    = dirBit;
        padOut   = outBit;
        pullupEn = pullDecode(dirBit, outBit, pullupDisable);
      end
    end
  end
endmodule : gdp_pin_drive
`default_nettype wire

// ===== tb/gdp_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
// =====================================================
// external circuitry seen at the pins
module gdp_pin_model (
  input  wire logic [7:0] padOut,
  input  wire logic [7:0] padOe,
  input  wire logic [7:0] pullupEn,
  input  wire logic [7:0] extVal,
  input  wire logic [7:0] extEn,
  output var  logic [7:0] pinLevel
);
  logic [7:0] lastDrv;
  initial begin
    pinLevel = 8'h00;
    lastDrv  = 8'h00;
  end
  // floating pin shows the inverse of its last driven level
  always @(padOut or padOe or pullupEn or extVal or extEn) begin
    for (int i = 0; i < 8; i++) begin
      if (padOe[i]) begin
        pinLevel[i] = padOut[i];
        lastDrv[i]  = padOut[i];
      end else if (extEn[i]) begin
        pinLevel[i] = extVal[i];
        lastDrv[i]  = extVal[i];
      end else if (pullupEn[i]) begin
        pinLevel[i] = 1'b1;
      end else begin
        pinLevel[i] = ~lastDrv[i];
      end
    end
  end
endmodule : gdp_pin_model
`default_nettype wire

// ===== tb/general_digital_io_port_bench.sv
`timescale 1ns/10ps
`default_nettype none
// =====================================================
// bench top
module general_digital_io_port_bench;
  import gdp_pkg::*;
  logic       clock, rst_n, global_pullup_disable;
  gdp_op_t    dirOp, outOp;
  logic [2:0] dirSel, outSel;
  logic [7:0] dirWr, outWr, altEn, altOe, altVal, extVal, extEn;
  logic [7:0] padOut, padOe, pullupEn, dirReg, outReg, inReg, pin;
  logic [7:0] expDir, expOut;
  int         num_errors = 0;
  int         checked = 0;
  gdp_io_port #(.W(8)) gdp_io_port_inst (.clock(clock), .rst_n(rst_n),
    .dirOp(dirOp), .dirWrData(dirWr), .dirBitSel(dirSel), .outOp(outOp),
    .outWrData(outWr), .outBitSel(outSel), .globalPullupDisable(global_pullup_disable),
    .altEnable(altEn), .altDriveEn(altOe), .altDriveVal(altVal),
    .padIn(pin), .padOut(padOut), .padOe(padOe), .pullupEn(pullupEn),
    .portDirectionRegister(dirReg), .portOutputRegister(outReg),
    .portInputRegister(inReg));
  gdp_pin_model gdp_pin_model_inst (.padOut(padOut), .padOe(padOe),
    .pullupEn(pullupEn), .extVal(extVal), .extEn(extEn), .pinLevel(pin));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // entered and left just after a rising edge
  task automatic op(input logic d, input gdp_op_t o, input logic [7:0] v,
                    input logic [2:0] s);
    if (d) begin
      dirOp = o; dirWr = v; dirSel = s;
    end else begin
      outOp = o; outWr = v; outSel = s;
    end
    @(posedge clock);
    #5;
  endtask : op
  task automatic idle;
    dirOp = GDP_OP_NONE;
    outOp = GDP_OP_NONE;
    @(posedge clock);
    #5;
  endtask : idle
  task end_sim;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial begin
    #100000;
    num_errors++;
    end_sim();
  end
  initial begin
    rst_n = 1'b0; global_pullup_disable = 1'b0; dirOp = GDP_OP_NONE; outOp = GDP_OP_NONE;
    dirWr = 8'h00; outWr = 8'h00; dirSel = 3'h0; outSel = 3'h0;
    altEn = 8'h00; altOe = 8'h00; altVal = 8'h00;
    extVal = 8'ha0; extEn = 8'hf0;
    repeat (20) @(posedge clock);
    chk(padOe | pullupEn | dirReg | outReg, 8'h00);
    #5 rst_n = 1'b1;
    op(0, GDP_OP_WRITE, 8'hc3, 3'h0);
    op(1, GDP_OP_WRITE, 8'h0f, 3'h0);
    chk(dirReg, 8'h0f);
    chk(outReg, 8'hc3);
    chk(padOe, 8'h0f);
    chk(padOut & padOe, 8'h03);
    chk(pullupEn, 8'hc0);
    global_pullup_disable = 1'b1;
    idle();
    chk(pullupEn, 8'h00);
    chk(inReg, 8'ha3);
    global_pullup_disable = 1'b0;
    #1 chk(pullupEn, 8'hc0);
    extVal = 8'h50;
    #30 chk(inReg, 8'ha3);
    extVal = 8'h00;
    #20 chk(inReg, 8'h53);
    @(posedge clock);
    #5 chk(inReg, 8'h03);
    expDir = 8'h0f;
    expOut = 8'hc3;
    for (int i = 0; i < 8; i++) begin
      op(1, GDP_OP_SET, 8'h00, 3'(i));
      op(0, GDP_OP_CLEAR, 8'hff, 3'(i));
      expDir[i] = 1'b1;
      expOut[i] = 1'b0;
      chk(dirReg, expDir);
      chk(outReg, expOut);
      chk(padOe, expDir);
    end
    op(0, GDP_OP_WRITE, 8'haa, 3'h0);
    chk(padOut | pullupEn, 8'haa);
    altEn = 8'h80;
    idle();
    chk(padOe, 8'h7f);
    chk(padOut & 8'h7f, 8'h2a);
    rst_n = 1'b0;
    #1 chk(padOe | pullupEn, 8'h00);
    chk(dirReg | outReg, 8'h00);
    end_sim();
  end
endmodule : general_digital_io_port_bench
`default_nettype wire
